// ### core/srcc_pkg.sv
// constants for the stop-recovery clock control block
package srcc_pkg;
   // stop-recovery control register fields
   localparam int SRC_PRESCALE_BIT = 0;
   localparam int SRC_SOURCE_LO    = 2;
   localparam int SRC_SOURCE_HI    = 4;
   localparam int SRC_DELAY_BIT    = 5;
   localparam logic [7:0] SRC_RESET = 8'h00;
   // port 3 mode register fields
   localparam int P3M_ANALOG_BIT    = 1;
   localparam logic [7:0] P3M_RESET = 8'h00;
   // interrupt request register edge-select fields
   localparam int IRQ_EDGE_LO = 6;
   localparam int IRQ_EDGE_HI = 7;
   localparam logic [7:0] IRQ_RESET = 8'h00;
   // interrupt mask register: bit 7 global, bits 5:0 per request
   localparam int IMR_GLOBAL_BIT    = 7;
   localparam int NUM_IRQ           = 6;
   localparam logic [7:0] IMR_RESET = 8'h00;
   // edge modes
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h2;
   // prescaler
   localparam int PRESCALE_DIV = 16;
   localparam logic [3:0] PRESCALE_LAST = 4'hf;
   // recovery delay: power-on-reset time, typical 5 ms lower end
   localparam int CLOCK_HZ     = 10_000_000;
   localparam int POR_DELAY_US = 5000;
   localparam int POR_DELAY_CYC = (POR_DELAY_US * (CLOCK_HZ / 1_000_000));
   localparam int DELAY_W       = 17;
   typedef enum logic [1:0] {SRCC_RUN, SRCC_STOP, SRCC_DELAY} srcc_state_e;
endpackage

// ### core/srcc_top.sv
// stop-mode recovery, clock prescale and interrupt steering
//
// Summary of operation
// - control bit 5 selects recovery delay
// - recovery delay lasts power-on-reset time
// - no delay: resume immediately on wake
// - bit 0 enables divide-by-16 prescaler
// - prescaled enables gate system and timer clocks
// - wake from stop clears prescale select
// - bits 4:2 select stop wake source
// - mode bit 1 enables analog comparators
// - irq bits 7:6 choose comparator edges
// - digital mode: interrupt from port3 bit3
// - analog mode: interrupt from wake logic
// - mask gates six requests globally, individually
`timescale 1ns/1ns
`default_nettype none
module srcc_top
   import srcc_pkg::*;
#(
   parameter int POR_CYCLES = POR_DELAY_CYC
) (
   input  wire logic               clock,
   input  wire logic               rst,
   // register writes from the core, same clock
   input  wire logic               stop_recovery_wr,
   input  wire logic               port3_mode_wr,
   input  wire logic               irq_ctrl_wr,
   input  wire logic               irq_mask_wr,
   input  wire logic [7:0]         wr_data,
   input  wire logic               stop_req,
   // asynchronous pins and comparator levels
   input  wire logic               port3_bit1_pin,
   input  wire logic               port3_bit2_pin,
   input  wire logic               port3_bit3_pin,
   input  wire logic               comparator_reference_pin,
   input  wire logic [3:0]         wake_pins,
   input  wire logic [NUM_IRQ-4:0] other_irq_req,
   output logic [7:0]              stop_recovery_control_reg,
   output logic [7:0]              port3_mode_reg,
   output logic [7:0]              irq_ctrl_reg,
   output logic [7:0]              irq_mask_reg,
   output logic                    sys_clock_en,
   output logic                    timer_irq_clock,
   output logic                    cpu_run,
   output logic                    stopped,
   output logic [NUM_IRQ-1:0]      irq_pending,
   output logic [NUM_IRQ-1:0]      irq_out
);
   typedef struct packed {
      srcc_state_e          state;
      logic [7:0]           src;
      logic [7:0]           p3m;
      logic [7:0]           irqc;
      logic [7:0]           imr;
      logic [3:0]           pre_cnt;
      logic [DELAY_W-1:0]   delay;
      logic [6:0]           s1;
      logic [6:0]           s2;
      logic [2:0]           prev;
      logic [NUM_IRQ-1:0]   pend;
      logic                 sys_en;
      logic                 tmr_en;
   } srcc_state_s;

   srcc_state_s st_reg;
   srcc_state_s st_next;

   // edge detect per chosen polarity
   function automatic logic edge_hit(input logic [1:0] mode, input logic now,
                                     input logic was);
      unique case (mode)
         EDGE_FALL: edge_hit = was & ~now;
         EDGE_RISE: edge_hit = ~was & now;
         default:   edge_hit = was ^ now;
      endcase
   endfunction

   logic       analog;
   logic       ch1;
   logic       ch2;
   logic       ch3;
   logic       wake_src;
   logic [1:0] edge_mode;
   logic [2:0] wake_sel;

   always_comb begin
      analog   = st_reg.p3m[P3M_ANALOG_BIT];
      // analog: pins compared with reference inputs
      ch1      = analog ? (st_reg.s2[0] & ~st_reg.s2[3]) : st_reg.s2[0];
      ch2      = analog ? (st_reg.s2[1] & ~st_reg.s2[2]) : st_reg.s2[1];
      wake_sel = st_reg.src[SRC_SOURCE_HI:SRC_SOURCE_LO];
      unique case (wake_sel)
         3'h0:    wake_src = 1'b0;
         3'h1:    wake_src = ch1;
         3'h2:    wake_src = ch2;
         3'h3:    wake_src = st_reg.s2[2];
         3'h4:    wake_src = st_reg.s2[3];
         3'h5:    wake_src = st_reg.s2[4];
         3'h6:    wake_src = st_reg.s2[5];
         default: wake_src = st_reg.s2[6];
      endcase
      ch3       = analog ? wake_src : st_reg.s2[2];
      edge_mode = st_reg.irqc[IRQ_EDGE_HI:IRQ_EDGE_LO];
   end

   always_comb begin
      st_next      = st_reg;
      // pins pass two flops before use
      st_next.s1   = {wake_pins[3:1], comparator_reference_pin, port3_bit3_pin,
                      port3_bit2_pin, port3_bit1_pin};
      st_next.s2   = st_reg.s1;
      st_next.prev = {ch3, ch2, ch1};
      if (stop_recovery_wr) st_next.src = wr_data;
      if (port3_mode_wr)    st_next.p3m = wr_data;
      if (irq_ctrl_wr)      st_next.irqc = wr_data;
      if (irq_mask_wr)      st_next.imr = wr_data;
      // pending bits: core clears via writes of irq control; set wins
      if (irq_ctrl_wr) st_next.pend = st_reg.pend & wr_data[NUM_IRQ-1:0];
      st_next.pend[0] = st_next.pend[0] | edge_hit(edge_mode, ch1, st_reg.prev[0]);
      st_next.pend[1] = st_next.pend[1] | edge_hit(edge_mode, ch2, st_reg.prev[1]);
      st_next.pend[2] = st_next.pend[2] | (st_reg.prev[2] & ~ch3);
      st_next.pend[NUM_IRQ-1:3] = st_next.pend[NUM_IRQ-1:3] | other_irq_req;
      // prescaler counter; divider off gives an enable every cycle outside stop (system enable in run only)
      st_next.pre_cnt = st_reg.pre_cnt + 4'h1;
      st_next.sys_en  = 1'b0;
      st_next.tmr_en  = 1'b0;
      if (!st_reg.src[SRC_PRESCALE_BIT] || st_reg.pre_cnt == PRESCALE_LAST) begin
         st_next.sys_en = (st_reg.state == SRCC_RUN);
         st_next.tmr_en = (st_reg.state != SRCC_STOP);
      end
      unique case (st_reg.state)
         SRCC_RUN: begin
            if (stop_req) st_next.state = SRCC_STOP;
         end
         SRCC_STOP: begin
            if (wake_src) begin
               st_next.src[SRC_PRESCALE_BIT] = 1'b0;
               st_next.pre_cnt = 4'h0;
               if (st_reg.src[SRC_DELAY_BIT]) begin
                  st_next.state = SRCC_DELAY;
                  st_next.delay = DELAY_W'(POR_CYCLES - 1);
               end else begin
                  st_next.state = SRCC_RUN;
               end
            end
         end
         SRCC_DELAY: begin
            st_next.delay = st_reg.delay - DELAY_W'(1);
            if (st_reg.delay == '0) st_next.state = SRCC_RUN;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_reg       <= '0;
         st_reg.state <= SRCC_RUN;
         st_reg.src   <= SRC_RESET;
         st_reg.p3m   <= P3M_RESET;
         st_reg.irqc  <= IRQ_RESET;
         st_reg.imr   <= IMR_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign stop_recovery_control_reg = st_reg.src;
   assign port3_mode_reg  = st_reg.p3m;
   assign irq_ctrl_reg    = st_reg.irqc;
   assign irq_mask_reg    = st_reg.imr;
   assign sys_clock_en    = st_reg.sys_en;
   assign timer_irq_clock = st_reg.tmr_en;
   assign cpu_run         = (st_reg.state == SRCC_RUN);
   assign stopped         = (st_reg.state == SRCC_STOP);
   assign irq_pending     = st_reg.pend;
   // global bit and per-request bits both gate
   assign irq_out = st_reg.pend & st_reg.imr[NUM_IRQ-1:0]
                    & {NUM_IRQ{st_reg.imr[IMR_GLOBAL_BIT]}};
endmodule // srcc_top
`default_nettype wire

// ### verif/srcc_checker.sv
// assertion checker for the stop-recovery clock control
`timescale 1ns/1ns
`default_nettype none
module srcc_checker
   import srcc_pkg::*;
(
   input wire logic               clock,
   input wire logic               rst,
   input wire logic               stop_recovery_wr,
   input wire logic               port3_mode_wr,
   input wire logic               irq_ctrl_wr,
   input wire logic [7:0]         wr_data,
   input wire logic               stop_req,
   input wire logic [7:0]         stop_recovery_control_reg,
   input wire logic [7:0]         port3_mode_reg,
   input wire logic [7:0]         irq_ctrl_reg,
   input wire logic [7:0]         irq_mask_reg,
   input wire logic               sys_clock_en,
   input wire logic               timer_irq_clock,
   input wire logic               cpu_run,
   input wire logic               stopped,
   input wire logic [NUM_IRQ-1:0] irq_pending,
   input wire logic [NUM_IRQ-1:0] irq_out
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   wire logic [7:0] c = stop_recovery_control_reg;
   wire logic [1:0] edge_wd = wr_data[7:6];
   a_stop_entry: assert property (cpu_run && stop_req |=> stopped) else $error("stop missed");
   a_wake_clear: assert property ($fell(stopped) |-> !c[0]) else $error("prescale kept");
   a_fast_wake: assert property ($fell(stopped) && !c[5] |-> cpu_run) else $error("wake slow");
   // the delay must last well beyond the sync path, then end
   a_delay_wait: assert property ($fell(stopped) && c[5] |-> !cpu_run [*8] ##[1:1000] cpu_run)
      else $error("delay wrong");
   a_irq_gate: assert property (irq_out == (irq_pending & irq_mask_reg[5:0]
      & {NUM_IRQ{irq_mask_reg[7]}})) else $error("mask wrong");
   // the pulse that rides on the enabling write is not a divided one
   a_prescale_gap: assert property (sys_clock_en && c[0] && $past(c[0]) |=> !sys_clock_en [*8])
      else $error("prescale fast");
   a_src_write: assert property (stop_recovery_wr |=> c == $past(wr_data))
      else $error("ctrl write lost");
   a_mode_write: assert property (port3_mode_wr |=> port3_mode_reg == $past(wr_data))
      else $error("mode write lost");
   a_edge_write: assert property (irq_ctrl_wr |=> irq_ctrl_reg[7:6] == $past(edge_wd))
      else $error("edge write lost");
   a_no_source: assert property (stopped && c[4:2] == 3'h0 |=> stopped)
      else $error("woke with no source");
   a_timer_stop: assert property (stopped |=> !timer_irq_clock)
      else $error("timer clock in stop");
endmodule // srcc_checker
bind srcc_top srcc_checker chk (.*);
`default_nettype wire

// ### verif/srcc_pins.sv
// model of the wake pins and comparator inputs
`timescale 1ns/1ns
`default_nettype none
module srcc_pins (
   input  wire logic       clock,
   input  wire logic [2:0] sel,
   output logic            port3_bit1_pin,
   output logic            port3_bit2_pin,
   output logic            port3_bit3_pin,
   output logic            comparator_reference_pin,
   output logic [3:0]      wake_pins
);
   // only the chosen source is high; all others rest low
   always_ff @(posedge clock) begin
      port3_bit1_pin <= sel == 3'h1;
      port3_bit2_pin <= sel == 3'h2;
      port3_bit3_pin <= sel == 3'h3;
      comparator_reference_pin <= sel == 3'h4;
      wake_pins <= {sel == 3'h7, sel == 3'h6, sel == 3'h5, 1'b0};
   end
endmodule // srcc_pins
`default_nettype wire

// ### verif/srcc_top_bench.sv
// directed bench for the stop-recovery clock control
`timescale 1ns/1ns
`default_nettype none
module srcc_top_bench;
   import srcc_pkg::*;
   logic clock = 1'b0, rst = 1'b1, stop_req = 1'b0;
   logic [3:0] w = 4'h0;
   logic [7:0] wr_data = 8'h00;
   logic [2:0] sel = 3'h0, other_irq_req = 3'h0;
   wire logic port3_bit1_pin, port3_bit2_pin, port3_bit3_pin, comparator_reference_pin;
   wire logic [3:0] wake_pins;
   wire logic [7:0] stop_recovery_control_reg;
   wire logic sys_clock_en, cpu_run, stopped;
   wire logic [5:0] irq_pending, irq_out;
   int fails = 0, num_checks = 0, n;
   srcc_pins pins (.*);
   srcc_top #(.POR_CYCLES(20)) dut (.*, .stop_recovery_wr(w[0]), .port3_mode_wr(w[1]),
      .irq_ctrl_wr(w[2]), .irq_mask_wr(w[3]), .port3_mode_reg(), .irq_ctrl_reg(),
      .irq_mask_reg(), .timer_irq_clock());
   initial forever #50 clock = ~clock;
   task summarize;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask
   task wr(input int k, input logic [7:0] d);
      @(posedge clock);
      wr_data <= d;
      w <= 4'h1 << k;
      @(posedge clock);
      w <= 4'h0;
   endtask
   task stop;
      // let the last source fall through the synchroniser first
      repeat (4) @(posedge clock);
      stop_req <= 1'b1;
      @(posedge clock);
      stop_req <= 1'b0;
      @(negedge clock);
   endtask
   task wake(input logic [2:0] s, output int t);
      @(posedge clock);
      sel <= s;
      for (t = 0; t < 100 && cpu_run !== 1'b1; t++) @(negedge clock);
      @(posedge clock);
      sel <= 3'h0;
      repeat (6) @(negedge clock);
   endtask
   initial begin
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      @(negedge clock);
      chk("ctrl reset", SRC_RESET, stop_recovery_control_reg);
      wr(0, 8'h0d);
      n = 0;
      @(negedge clock);
      repeat (32) @(negedge clock) n += sys_clock_en;
      chk("prescale pulses", 8'h02, n[7:0]);
      stop;
      chk("stopped", 8'h01, {7'h0, stopped});
      wake(3'h3, n);
      chk("fast wake", 8'h01, {7'h0, n <= 6});
      chk("prescale cleared", 8'h0c, stop_recovery_control_reg);
      $display("test fast wake done");
      wr(0, 8'h2c);
      stop;
      wake(3'h3, n);
      chk("slow wake", 8'h01, {7'h0, n > 20});
      wr(0, 8'h00);
      stop;
      wake(3'h3, n);
      chk("no source", 8'h00, {7'h0, cpu_run});
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      $display("test wake delay done");
      wr(3, 8'h84);
      wake(3'h3, n);
      chk("digital irq", 8'h04, {2'h0, irq_out});
      wr(3, 8'h04);
      @(negedge clock);
      chk("global off", 8'h00, {2'h0, irq_out});
      for (int k = 0; k < 3; k++) wr(2, {k[1:0], 6'h3f});
      wr(2, 8'h00);
      wr(1, 8'h02);
      wr(0, 8'h14);
      wake(3'h3, n);
      chk("analog pin3", 8'h00, {2'h0, irq_pending});
      wake(3'h5, n);
      chk("analog wake src", 8'h04, {2'h0, irq_pending});
      $display("test irq steering done");
      summarize;
   end
   initial begin
      #300000;
      fails++;
      summarize;
   end
endmodule // srcc_top_bench
`default_nettype wire
